// >>> src/cft_pkg.sv
// Constants, field layouts and types for the CAN filter and transmit handler
package cft_pkg;
    localparam int ID_W = 29;        // Extended identifier width
    localparam int STD_W = 11;       // Standard identifier width
    localparam int NBUF = 8;         // Buffers 0..3 dedicated, 4..7 FIFO slots
    localparam int NDED = 4;         // Dedicated buffers
    localparam int PIPE = 3;         // Output pipeline positions
    // Register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_STD_FILT = 8'h04;
    localparam logic [7:0] OFS_EXT_FILT0 = 8'h08;
    localparam logic [7:0] OFS_EXT_FILT1 = 8'h0c;
    localparam logic [7:0] OFS_ADD_REQ = 8'h10;
    localparam logic [7:0] OFS_PENDING = 8'h14;
    localparam logic [7:0] OFS_OCCURRED = 8'h18;
    localparam logic [7:0] OFS_IRQ_FLAGS = 8'h1c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
    localparam logic [7:0] OFS_CANCEL = 8'h24;
    localparam logic [7:0] OFS_FIFO_PUT = 8'h28;
    localparam logic [7:0] OFS_FIFO_STAT = 8'h2c;
    localparam logic [2:0] OFS_BUFID_HI = 3'h2; // Buffer IDs at 0x40 + 4*n
    // Filter element field positions
    localparam int STD_TYPE_LSB = 30;
    localparam int STD_CFG_LSB = 27;
    localparam int STD_ID1_LSB = 16;
    localparam int EXT_CFG_LSB = 29;
    localparam int EXT_TYPE_LSB = 30;
    // Element codes
    localparam logic [2:0] CFG_FIFO0 = 3'h1;
    localparam logic [2:0] CFG_FIFO1 = 3'h2;
    localparam logic [1:0] TYPE_CLASSIC = 2'h2;
    // Interrupt flag positions
    localparam int IRQ_W = 4;
    localparam int IRQ_TC = 0;
    localparam int IRQ_TFE = 1;
    localparam int IRQ_RF0 = 2;
    localparam int IRQ_RF1 = 3;
    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [STD_W-1:0] RST_ID = 11'h7ff;

    typedef logic [2:0] cft_bidx_t;
    typedef struct packed {
        logic valid;
        cft_bidx_t idx;
        logic [STD_W-1:0] id;
    } cft_pent_t;
    typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_ACTIVE} cft_txst_t;
endpackage : cft_pkg

// >>> src/cft_filt_if.sv
// Interface between the handler and one acceptance filter element
`timescale 1ns/1ps
`default_nettype none
interface cft_filt_if;
    logic [cft_pkg::ID_W-1:0] rxId;  // Received identifier
    logic [cft_pkg::ID_W-1:0] id1;   // Filter value
    logic [cft_pkg::ID_W-1:0] id2;   // Mask
    logic [2:0] cfg;                 // Element configuration
    logic [1:0] ftype;               // Element type
    logic hit;                       // Element accepts frame
    logic toFifo1;                   // Store target is FIFO 1
    modport elem (input rxId, id1, id2, cfg, ftype, output hit, toFifo1);
    modport ctl (output rxId, id1, id2, cfg, ftype, input hit, toFifo1);
endinterface : cft_filt_if
`default_nettype wire

// >>> src/cft_filter_elem.sv
// One classic acceptance filter element; the handler has one instance for standard and one for extended frames
`timescale 1ns/1ps
`default_nettype none
module cft_filter_elem (
    cft_filt_if.elem f  // Element configuration and result
);
    import cft_pkg::*;
    logic storeCfg;  // Config names a receive FIFO
    logic idMatch;   // Unmasked bits agree

    // Only FIFO store configs accept; others reject
    assign storeCfg = (f.cfg == CFG_FIFO0) || (f.cfg == CFG_FIFO1);
    // Mask bit zero means the ID bit is ignored
    assign idMatch = ((f.rxId ^ f.id1) & f.id2) == '0;
    // Only the classic type is built; other types never match
    assign f.hit = storeCfg && (f.ftype == TYPE_CLASSIC) && idMatch;
    assign f.toFifo1 = (f.cfg == CFG_FIFO1);
endmodule : cft_filter_elem
`default_nettype wire

// >>> src/cft_handler.sv
// Top level: filters, transmit message handler, flags and Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none
module cft_handler (
    input wire logic clk,                              // 100 MHz clock
    input wire logic rst_b,                            // Async reset, active low
    input wire logic [7:0] avs_address,                // Byte address
    input wire logic avs_read,                         // Read request
    input wire logic avs_write,                        // Write request
    input wire logic [31:0] avs_writedata,             // Write data
    output logic [31:0] avs_readdata,                  // Read data
    output logic avs_waitrequest,                      // Stall request
    output logic irq,                                  // Level interrupt
    input wire logic rxFrameValid,                     // Frame received pulse
    input wire logic rxFrameExt,                       // Frame is extended
    input wire logic [cft_pkg::ID_W-1:0] rxFrameId,    // Received identifier
    output logic rxToFifo0,                            // Store in FIFO 0 pulse
    output logic rxToFifo1,                            // Store in FIFO 1 pulse
    output logic txRequest,                            // Request to engine
    output logic [2:0] txBufIndex,                     // Buffer being sent
    output logic [cft_pkg::STD_W-1:0] txId,            // Identifier being sent
    input wire logic txDone,                           // Sent successfully pulse
    input wire logic txFail                            // Lost or error pulse
);
    import cft_pkg::*;

    // Software state
    logic cfgQueue_q;                      // 0: buffers plus FIFO, 1: queue
    logic [31:0] stdFilt_q;                // Standard element word
    logic [31:0] extFilt0_q;               // Extended element word 0
    logic [31:0] extFilt1_q;               // Extended element word 1
    logic [STD_W-1:0] bufId_q [NBUF];      // Per buffer identifier
    logic [NBUF-1:0] pending_q;            // Request pending
    logic [NBUF-1:0] occurred_q;           // Transmission occurred
    logic [IRQ_W-1:0] flags_q;             // Sticky event flags
    logic [IRQ_W-1:0] flags_d;             // Flags next value
    logic [IRQ_W-1:0] mask_q;              // Interrupt enables
    logic [1:0] putIdx_q;                  // Next FIFO slot to fill
    logic [1:0] getIdx_q;                  // Oldest FIFO slot
    // Handler state
    cft_pent_t pipe_q [PIPE];              // Output pipeline
    cft_pent_t pipe_d [PIPE];              // Pipeline next value
    cft_txst_t state_q;                    // Handoff state
    logic waitreq_q;                       // Bus stall
    logic [31:0] rdata_q;                  // Read data
    logic irq_q;                           // Interrupt level
    logic rx0_q;                           // FIFO 0 store pulse
    logic rx1_q;                           // FIFO 1 store pulse
    logic txReq_q;                         // Engine request
    cft_bidx_t outIdx_q;                   // Output buffer index
    logic [STD_W-1:0] outId_q;             // Output buffer identifier

    // Bus decode
    logic wrEn;                            // Write takes effect
    logic [NBUF-1:0] addSet;               // Newly requested buffers
    logic [NBUF-1:0] cancelClr;            // Cancelled buffers
    logic [NBUF-1:0] doneClr;              // Completed buffer
    logic fifoPut;                         // FIFO element queued
    logic headDone;                        // Active head succeeded
    logic headFail;                        // Active head failed
    logic tfeEvt;                          // FIFO drained event
    logic [IRQ_W-1:0] evt;                 // Flag events this cycle

    assign wrEn = avs_write && !waitreq_q;
    assign headDone = (state_q == TX_ACTIVE) && txDone;
    assign headFail = (state_q == TX_ACTIVE) && txFail && !txDone;

    // Acceptance filters, one element per frame format
    cft_filt_if stdIf ();
    cft_filt_if extIf ();
    cft_filter_elem u_std (.f(stdIf.elem));
    cft_filter_elem u_ext (.f(extIf.elem));
    assign stdIf.rxId = {{(ID_W-STD_W){1'b0}}, rxFrameId[STD_W-1:0]};
    assign stdIf.id1 = {{(ID_W-STD_W){1'b0}}, stdFilt_q[STD_ID1_LSB +: STD_W]};
    assign stdIf.id2 = {{(ID_W-STD_W){1'b0}}, stdFilt_q[STD_W-1:0]};
    assign stdIf.cfg = stdFilt_q[STD_CFG_LSB +: 3];
    assign stdIf.ftype = stdFilt_q[STD_TYPE_LSB +: 2];
    assign extIf.rxId = rxFrameId;
    assign extIf.id1 = extFilt0_q[ID_W-1:0];
    assign extIf.id2 = extFilt1_q[ID_W-1:0];
    assign extIf.cfg = extFilt0_q[EXT_CFG_LSB +: 3];
    assign extIf.ftype = extFilt1_q[EXT_TYPE_LSB +: 2];

    // Route accepted frames, one-cycle pulses from flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx0_q <= 1'b0;
            rx1_q <= 1'b0;
        end else if (rxFrameExt) begin
            rx0_q <= rxFrameValid && extIf.hit && !extIf.toFifo1;
            rx1_q <= rxFrameValid && extIf.hit && extIf.toFifo1;
        end else begin
            rx0_q <= rxFrameValid && stdIf.hit && !stdIf.toFifo1;
            rx1_q <= rxFrameValid && stdIf.hit && stdIf.toFifo1;
        end
    end

    // Bus stall: drop for one cycle after a request is seen
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            waitreq_q <= 1'b1;
        end else if ((avs_read || avs_write) && waitreq_q) begin
            waitreq_q <= 1'b0;
        end else begin
            waitreq_q <= 1'b1;
        end
    end

    // Read data is prepared while the stall is still high
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= RST_WORD;
        end else if (avs_read && waitreq_q) begin
            rdata_q <= RST_WORD;
            if (avs_address[7:5] == OFS_BUFID_HI) begin
                rdata_q[STD_W-1:0] <= bufId_q[avs_address[4:2]];
            end else begin
                unique case (avs_address)
                    OFS_CONFIG: rdata_q[0] <= cfgQueue_q;
                    OFS_STD_FILT: rdata_q <= stdFilt_q;
                    OFS_EXT_FILT0: rdata_q <= extFilt0_q;
                    OFS_EXT_FILT1: rdata_q <= extFilt1_q;
                    OFS_PENDING: rdata_q[NBUF-1:0] <= pending_q;
                    OFS_OCCURRED: rdata_q[NBUF-1:0] <= occurred_q;
                    OFS_IRQ_FLAGS: rdata_q[IRQ_W-1:0] <= flags_q;
                    OFS_IRQ_MASK: rdata_q[IRQ_W-1:0] <= mask_q;
                    OFS_FIFO_STAT: rdata_q[3:0] <= {getIdx_q, putIdx_q};
                    default: rdata_q <= RST_WORD; // Unmapped reads zero
                endcase
            end
        end
    end

    // Configuration and filter words
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfgQueue_q <= 1'b0;
            stdFilt_q <= RST_WORD;
            extFilt0_q <= RST_WORD;
            extFilt1_q <= RST_WORD;
            mask_q <= '0;
        end else if (wrEn) begin
            if (avs_address == OFS_CONFIG) cfgQueue_q <= avs_writedata[0];
            if (avs_address == OFS_STD_FILT) stdFilt_q <= avs_writedata;
            if (avs_address == OFS_EXT_FILT0) extFilt0_q <= avs_writedata;
            if (avs_address == OFS_EXT_FILT1) extFilt1_q <= avs_writedata;
            if (avs_address == OFS_IRQ_MASK) mask_q <= avs_writedata[IRQ_W-1:0];
        end
    end

    // Request decode; FIFO slots are requested only through the put port
    always_comb begin
        addSet = '0;
        cancelClr = '0;
        doneClr = '0;
        fifoPut = wrEn && (avs_address == OFS_FIFO_PUT) && !pending_q[{1'b1, putIdx_q}];
        if (wrEn && avs_address == OFS_ADD_REQ) addSet[NDED-1:0] = avs_writedata[NDED-1:0];
        if (fifoPut) addSet[{1'b1, putIdx_q}] = 1'b1;
        if (wrEn && avs_address == OFS_CANCEL) cancelClr[NDED-1:0] = avs_writedata[NDED-1:0];
        // The buffer handed to the engine cannot be cancelled mid-frame
        if (state_q != TX_IDLE) cancelClr[outIdx_q] = 1'b0;
        if (headDone) doneClr[outIdx_q] = 1'b1;
    end

    // Identifier store; FIFO slots filled in ring order
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int b = 0; b < NBUF; b++) bufId_q[b] <= RST_ID;
            putIdx_q <= '0;
        end else if (fifoPut) begin
            bufId_q[{1'b1, putIdx_q}] <= avs_writedata[STD_W-1:0];
            putIdx_q <= putIdx_q + 2'h1;
        end else if (wrEn && avs_address[7:5] == OFS_BUFID_HI && !avs_address[4]) begin
            bufId_q[avs_address[4:2]] <= avs_writedata[STD_W-1:0];
        end
    end

    // Pending bits: clear and occurred set share one edge; a new request wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pending_q <= '0;
            occurred_q <= '0;
        end else begin
            pending_q <= (pending_q & ~cancelClr & ~doneClr) | addSet;
            occurred_q <= (occurred_q & ~addSet) | doneClr;
        end
    end

    // Oldest FIFO slot advances only when it has gone out
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            getIdx_q <= '0;
        end else if (headDone && outIdx_q[2]) begin
            getIdx_q <= getIdx_q + 2'h1;
        end
    end

    // Message scan: purge, compact, then insert the best waiting request
    always_comb begin
        cft_pent_t work [PIPE];
        cft_pent_t comp [PIPE];
        cft_pent_t cand;
        logic [NBUF-1:0] inPipe;
        logic [1:0] nextFifo;
        logic lock;
        logic found;
        int n;
        int pos;
        for (int k = 0; k < PIPE; k++) begin
            work[k] = pipe_q[k];
            comp[k] = '0;
            pipe_d[k] = '0;
        end
        cand = '0;
        inPipe = '0;
        nextFifo = getIdx_q;
        found = 1'b0;
        n = 0;
        pos = 0;
        lock = (state_q == TX_LOAD) || ((state_q == TX_ACTIVE) && !txDone && !txFail);
        for (int k = 0; k < PIPE; k++) begin
            // Cancelled or finished entries drop out
            if (!pending_q[work[k].idx] && !(k == 0 && lock)) work[k].valid = 1'b0;
            if (k == 0 && (headDone || headFail)) work[k].valid = 1'b0;
            // A failed attempt flushes FIFO entries so they return in order
            if (headFail && !cfgQueue_q && work[k].idx[2]) work[k].valid = 1'b0;
        end
        for (int k = 0; k < PIPE; k++) begin
            if (work[k].valid) begin
                comp[n[1:0]] = work[k];
                n++;
            end
        end
        for (int k = 0; k < PIPE; k++) begin
            if (comp[k].valid) begin
                inPipe[comp[k].idx] = 1'b1;
                if (comp[k].idx[2]) nextFifo = nextFifo + 2'h1;
            end
        end
        // Lowest identifier wins; ties go to the lower buffer number
        for (int b = 0; b < NBUF; b++) begin
            if (pending_q[b] && !inPipe[b] && (b < NDED || cfgQueue_q || b[1:0] == nextFifo)
                && (!found || bufId_q[b] < cand.id)) begin
                found = 1'b1;
                cand.valid = 1'b1;
                cand.idx = b[2:0];
                cand.id = bufId_q[b];
            end
        end
        // Insert after equal or better entries, after queued FIFO ones, behind a locked head
        for (int k = 0; k < PIPE; k++) begin
            if (comp[k].valid && (comp[k].id <= cand.id || (k == 0 && lock)
                || (!cfgQueue_q && cand.idx[2] && comp[k].idx[2]))) pos = k + 1;
        end
        for (int k = 0; k < PIPE; k++) begin
            if (!found || k < pos) pipe_d[k] = comp[k];
            else if (k == pos) pipe_d[k] = cand;
            else pipe_d[k] = comp[k-1]; // Last entry falls out, rescanned later
        end
    end

    // Pipeline register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int k = 0; k < PIPE; k++) pipe_q[k] <= '0;
        end else begin
            for (int k = 0; k < PIPE; k++) pipe_q[k] <= pipe_d[k];
        end
    end

    // Handoff: load output buffer, raise request next cycle, drop on outcome
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= TX_IDLE;
            txReq_q <= 1'b0;
            outIdx_q <= '0;
            outId_q <= RST_ID;
        end else begin
            unique case (state_q)
                TX_IDLE: begin
                    if (pipe_d[0].valid) begin
                        outIdx_q <= pipe_d[0].idx;
                        outId_q <= pipe_d[0].id;
                        state_q <= TX_LOAD;
                    end
                end
                TX_LOAD: begin
                    txReq_q <= 1'b1;
                    state_q <= TX_ACTIVE;
                end
                TX_ACTIVE: begin
                    if (txDone || txFail) begin
                        txReq_q <= 1'b0;
                        state_q <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    // Events: set wins over a write-one clear in the same cycle
    assign tfeEvt = headDone && outIdx_q[2] && ((pending_q[NBUF-1:NDED] & ~doneClr[NBUF-1:NDED]) == '0);
    always_comb begin
        evt = '0;
        evt[IRQ_TC] = headDone;
        evt[IRQ_TFE] = tfeEvt;
        evt[IRQ_RF0] = rx0_q;
        evt[IRQ_RF1] = rx1_q;
        flags_d = flags_q;
        if (wrEn && avs_address == OFS_IRQ_FLAGS) flags_d = flags_q & ~avs_writedata[IRQ_W-1:0];
        flags_d = flags_d | evt;
    end

    // Sticky flags and masked interrupt level
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_q <= '0;
            irq_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            irq_q <= |(flags_d & mask_q);
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = waitreq_q;
    assign irq = irq_q;
    assign rxToFifo0 = rx0_q;
    assign rxToFifo1 = rx1_q;
    assign txRequest = txReq_q;
    assign txBufIndex = outIdx_q;
    assign txId = outId_q;
endmodule : cft_handler
`default_nettype wire

// >>> testbench/cft_handler_chk.sv
// Port checker for the CAN filter and transmit handler
`timescale 1ns/1ps
`default_nettype none
module cft_handler_chk (
    input wire logic clk, // Clock
    input wire logic rst_b, // Reset, active low
    input wire logic [7:0] avs_address, // Bus address
    input wire logic avs_read, // Bus read
    input wire logic avs_write, // Bus write
    input wire logic [31:0] avs_writedata, // Bus data
    input wire logic avs_waitrequest, // Bus stall
    input wire logic rxFrameValid, // Frame in
    input wire logic rxToFifo0, // Store in FIFO 0
    input wire logic rxToFifo1, // Store in FIFO 1
    input wire logic txRequest, // Offer to engine
    input wire logic [2:0] txBufIndex, // Buffer offered
    input wire logic [cft_pkg::STD_W-1:0] txId, // ID offered
    input wire logic txDone, // Engine success
    input wire logic txFail // Engine failure
);
    import cft_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Accepted request write while the engine is idle
    sequence addReq;
        avs_write && !avs_waitrequest && avs_address == OFS_ADD_REQ && avs_writedata[3:0] != 4'h0 && !txRequest;
    endsequence
    // Engine answers the current offer
    sequence answered;
        txRequest && (txDone || txFail);
    endsequence
    bus_stall_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered after one stall cycle");
    bus_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer held longer than one cycle");
    rx_cause_a: assert property (rxToFifo0 || rxToFifo1 |-> $past(rxFrameValid))
        else $error("store pulse without a received frame");
    rx_single_a: assert property (!(rxToFifo0 && rxToFifo1))
        else $error("frame stored in both FIFOs");
    tx_hold_a: assert property (txRequest && !txDone && !txFail |=>
        txRequest && $stable(txId) && $stable(txBufIndex))
        else $error("offer changed before the engine answered");
    tx_drop_a: assert property (answered |=> !txRequest)
        else $error("offer kept after the engine answered");
    tx_gap_a: assert property ($fell(txRequest) |-> !txRequest [*2])
        else $error("next offer sooner than the arbitration allows");
    tx_start_a: assert property (addReq |-> ##[1:5] txRequest)
        else $error("request write not handed to the engine");
endmodule : cft_handler_chk
bind cft_handler cft_handler_chk i_chk (.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .rxFrameValid(rxFrameValid), .rxToFifo0(rxToFifo0), .rxToFifo1(rxToFifo1), .txRequest(txRequest),
    .txBufIndex(txBufIndex), .txId(txId), .txDone(txDone), .txFail(txFail));
`default_nettype wire

// >>> testbench/cft_can_node.sv
// Behavioural protocol engine standing for the other nodes on the bus
`timescale 1ns/1ps
`default_nettype none
module cft_can_node (
    input wire logic clk, // Clock
    input wire logic rst_b, // Reset, active low
    input wire logic txRequest, // Offer from the handler
    input wire logic failReq, // Bench orders a lost arbitration
    input wire logic slow, // Long frame time when high
    output logic txDone, // Frame acknowledged
    output logic txFail // Arbitration lost
);
    logic [4:0] cnt; // Stand-in for the frame time
    // One answer per offer; the count restarts once the offer drops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 5'h00;
            txDone <= 1'b0;
            txFail <= 1'b0;
        end else begin
            txDone <= 1'b0;
            txFail <= 1'b0;
            if (!txRequest || txDone || txFail) begin
                cnt <= 5'h00; // Idle or just answered
            end else if (cnt == (slow ? 5'h14 : 5'h02)) begin
                txDone <= !failReq; // Single pulse, never both
                txFail <= failReq;
            end else begin
                cnt <= cnt + 5'h01;
            end
        end
    end
endmodule : cft_can_node
`default_nettype wire

// >>> testbench/cft_handler_tb.sv
// Self-checking bench for the CAN filter and transmit handler
`timescale 1ns/1ps
`default_nettype none
module cft_handler_tb;
    import cft_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0, avs_write = 1'b0, rxFrameValid = 1'b0, rxFrameExt = 1'b0, failReq = 1'b0, slow = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [ID_W-1:0] rxFrameId = 29'h0;
    logic avs_waitrequest, irq, rxToFifo0, rxToFifo1, txRequest, txDone, txFail, f;
    logic [2:0] txBufIndex, idx;
    logic [STD_W-1:0] txId;
    int n_mismatch = 0;
    int n_checks = 0;
    cft_handler i_dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .rxFrameValid(rxFrameValid), .rxFrameExt(rxFrameExt),
        .rxFrameId(rxFrameId), .rxToFifo0(rxToFifo0), .rxToFifo1(rxToFifo1), .txRequest(txRequest),
        .txBufIndex(txBufIndex), .txId(txId), .txDone(txDone), .txFail(txFail));
    cft_can_node i_node (.clk(clk), .rst_b(rst_b), .txRequest(txRequest), .failReq(failReq), .slow(slow),
        .txDone(txDone), .txFail(txFail));
    // Free-running clock
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic conclude;
        if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One Avalon access; a spare edge after release avoids double drives
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50) begin
            n_mismatch++;
            conclude();
        end
        @(posedge clk);
    endtask : bus
    // Offer one frame and judge the store pulse a cycle later
    task automatic rxChk(input logic ext, input logic [28:0] id, input logic e0, input logic e1);
        rxFrameExt <= ext;
        rxFrameId <= id;
        rxFrameValid <= 1'b1;
        @(posedge clk);
        rxFrameValid <= 1'b0;
        @(posedge clk);
        chk({rxToFifo1, rxToFifo0}, {e1, e0});
    endtask : rxChk
    // Bounded wait for the engine's answer; returns buffer and outcome
    task automatic waitEnd(output logic [2:0] bi, output logic bad);
        int n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!(txRequest === 1'b1 && (txDone === 1'b1 || txFail === 1'b1)) && n < 200);
        bi = txBufIndex;
        bad = txFail;
        if (n >= 200) begin
            n_mismatch++;
            conclude();
        end
    endtask : waitEnd
    // Reset values, read-only and unmapped places
    task automatic scnReset;
        bus(0, OFS_PENDING, 0, rd);
        chk(rd, 32'h0);
        bus(0, 8'h40, 0, rd);
        chk(rd, {21'h0, RST_ID});
        bus(1, OFS_PENDING, 32'hff, rd);
        bus(0, OFS_PENDING, 0, rd);
        chk(rd, 32'h0);
        bus(0, 8'h30, 0, rd);
        chk(rd, 32'h0);
    endtask : scnReset
    // Classic filters with zero and full masks, both FIFO targets
    task automatic scnFilter;
        for (int c = 1; c <= 2; c++) begin
            bus(1, OFS_STD_FILT, {TYPE_CLASSIC, c[2:0], 11'h123, 5'h0, 11'h000}, rd);
            rxChk(0, 29'h5a5, c == 1, c == 2);
            bus(1, OFS_EXT_FILT0, {c[2:0], 29'h1abcdef0}, rd);
            bus(1, OFS_EXT_FILT1, {TYPE_CLASSIC, 1'b0, 29'h0}, rd);
            rxChk(1, 29'h0f0f0f0f, c == 1, c == 2);
        end
        bus(1, OFS_STD_FILT, {TYPE_CLASSIC, CFG_FIFO0, 11'h123, 5'h0, 11'h7ff}, rd);
        rxChk(0, 29'h124, 0, 0);
        rxChk(0, 29'h123, 1, 0);
        bus(0, OFS_IRQ_FLAGS, 0, rd);
        chk(rd & 32'hc, 32'hc);
        bus(1, OFS_IRQ_FLAGS, 32'hf, rd);
    endtask : scnFilter
    // Three buffers requested at once leave in ID order; interrupt raised and masked
    task automatic scnTxPrio;
        logic [13:0] ord [3] = '{{11'h010, 3'd3}, {11'h050, 3'd1}, {11'h200, 3'd2}};
        bus(1, OFS_IRQ_MASK, 32'h1, rd);
        bus(1, 8'h44, 32'h050, rd);
        bus(1, 8'h48, 32'h200, rd);
        bus(1, 8'h4c, 32'h010, rd);
        bus(1, OFS_ADD_REQ, 32'he, rd);
        for (int i = 0; i < 3; i++) begin
            waitEnd(idx, f);
            chk({f, txId, idx}, {1'b0, ord[i]});
        end
        bus(0, OFS_OCCURRED, 0, rd);
        chk(rd, 32'h0e);
        bus(0, OFS_PENDING, 0, rd);
        chk(rd, 32'h0);
        chk(irq, 1'b1);
        bus(1, OFS_IRQ_MASK, 32'h0, rd);
        @(posedge clk);
        chk(irq, 1'b0);
        bus(1, OFS_IRQ_FLAGS, 32'h1, rd);
        bus(0, OFS_IRQ_FLAGS, 0, rd);
        chk(rd, 32'h0);
    endtask : scnTxPrio
    // Failed FIFO head overtaken by a dedicated buffer; FIFO order must hold
    task automatic scnFifoOrder;
        logic [2:0] ord [3] = '{3'd0, 3'd4, 3'd5};
        int n = 0;
        slow <= 1'b1;
        failReq <= 1'b1;
        bus(1, OFS_FIFO_PUT, 32'h300, rd);
        bus(1, OFS_FIFO_PUT, 32'h301, rd);
        while (txRequest !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) begin
            n_mismatch++;
            conclude();
        end
        bus(1, 8'h40, 32'h100, rd);
        bus(1, OFS_ADD_REQ, 32'h1, rd);
        bus(0, OFS_PENDING, 0, rd);
        chk(rd, 32'h31);
        waitEnd(idx, f);
        chk({f, idx}, {1'b1, 3'd4});
        failReq <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            waitEnd(idx, f);
            chk({f, idx}, {1'b0, ord[i]});
        end
        bus(0, OFS_IRQ_FLAGS, 0, rd);
        chk(rd[1:0], 2'h3);
        bus(0, OFS_OCCURRED, 0, rd);
        chk(rd, 32'h3f);
    endtask : scnFifoOrder
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        scnReset();
        scnFilter();
        scnTxPrio();
        scnFifoOrder();
        conclude();
    end
endmodule : cft_handler_tb
`default_nettype wire
